// *** rtl/ewf_wake_link.sv ***
// Wake frame filters, link polling and wake/link status behind an APB slave
// Functional notes
// RULE1: Poll both PHY links every 200 ms; enabled change raises link interrupt.
// RULE2: Link-up and link-down transitions both count as link-change events.
// RULE3: Link enable bit 2 gates secondary link interrupts, reset disabled.
// RULE4: Status bits 0 and 2 set on link change, cleared by status read.
// RULE5: Status bits 1 and 3 show current primary and secondary link state.
// RULE6: Status bit 4 set on magic packet wake, cleared by status read.
// RULE7: Status bit 5 set on external pin wake, cleared by status read.
// RULE8: Status bit 6 set on filter frame wake, cleared by status read.
// RULE9: Software reads status after wake or link interrupt to find source.
// RULE10: Command bits 0 and 2 enable filters; software loads filter first.
// RULE11: Bits 1 and 3 additionally require destination equal station address.
// RULE12: Command bit 4 cascades; both masks, offsets, filter 1 CRC/tail used.
// RULE13: In cascade software sets both enables and equal unicast bits.
// RULE14: Cascaded second mask starts at byte offset0*2+32+offset1*2.
// RULE15: Each filter has 32-bit byte mask, mask byte 0 is bits 7..0.
// RULE16: CRC-16 x16+x15+x2+1 over masked bytes compared with stored CRC.
// RULE17: Filter offset counts two-byte units from first destination byte.
// RULE18: Tail byte compared with byte of highest set mask bit.
// RULE19: Mask bit n selects n-th byte from filter start.
// RULE20: Software writes filter command register last.
// RULE21: PHY control bit 0 selects embedded PHY, reset 1; 0 selects MII.
// RULE22: Enabled wake events drive the wake interrupt.
// RULE23: Software sets frame wake enable bit 6 before low power.
// RULE24: CRC starts at zero per frame, bytes in order, LSB first.
//
// Register access over APB was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module ewf_wake_link #(
  parameter int unsigned PollCycles = ewf_pkg::LINK_POLL_CYCLES
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ewf_pkg::ADDR_W-1:0] paddr,
  input wire logic [ewf_pkg::DATA_W-1:0] pwdata,
  output logic [ewf_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic primaryLinkUp,
  input wire logic secondaryLinkUp,
  input wire logic magicPacketSeen,
  input wire logic externalWakePin,
  input wire logic rxValid,
  input wire logic rxSof,
  input wire logic rxEof,
  input wire logic [7:0] rxData,
  output logic linkIrq,
  output logic wakeIrq,
  output logic phySelectEmbedded
);
  import ewf_pkg::*;

  function automatic logic isReg(input logic [ADDR_W-1:0] addr, input logic [9:0] idx);
    isReg = (addr == {idx, 2'b00});
  endfunction

  function automatic logic [15:0] crc16Byte(input logic [15:0] crcIn, input logic [7:0] d);
    logic [15:0] c;
    c = crcIn;
    for (int i = 0; i < 8; i++) begin
      if (c[15] ^ d[i]) begin
        c = {c[14:0], 1'b0} ^ CRC16_POLY;
      end else begin
        c = {c[14:0], 1'b0};
      end
    end
    crc16Byte = c;
  endfunction

  logic [7:0] wakeIrqEnable;
  logic [7:0] linkIrqEnable;
  logic [7:0] wakeFilterCommand;
  logic [47:0] stationMacAddress;
  logic [31:0] filterMask [2];
  logic [15:0] filterCrc [2];
  logic [7:0] filterStart [2];
  logic [7:0] filterTail [2];
  logic primaryLinkChangedFlag;
  logic secondaryLinkChangedFlag;
  logic primaryLinkState;
  logic secondaryLinkState;
  logic magicWakeFlag;
  logic pinWakeFlag;
  logic frameWakeFlag;
  logic [POLL_W-1:0] pollCnt;
  logic pollTick;
  logic primaryChange;
  logic secondaryChange;
  logic pinLast;
  logic pinWakeSet;
  logic magicWakeSet;
  logic frameWakeSet;
  logic setupPhase;
  logic accessPhase;
  logic wrEn;
  logic statusRead;
  logic mapped;
  logic [DATA_W-1:0] readValue;
  logic [7:0] statusValue;
  ewf_rx_state_t rxState;
  logic [10:0] posCnt;
  logic [10:0] byteIdx;
  logic accept;
  logic firstByte;
  logic [10:0] winStart [2];
  logic [1:0] hit;
  logic [1:0] feed;
  logic [15:0] crcAcc [2];
  logic [7:0] tailAcc [2];
  logic [1:0] anyAcc;
  logic daMatch;
  logic [2:0] daSel;
  logic [1:0] filterHit;
  logic frameMatch;
  logic cascade;

  // APB: data captured at setup so the access phase can always answer at once
  assign setupPhase = psel & ~penable;
  assign accessPhase = psel & penable;
  assign pready = 1'b1;
  assign wrEn = accessPhase & pwrite;
  assign statusRead = accessPhase & ~pwrite & isReg(paddr, IDX_WAKE_LINK_STATUS);

  assign statusValue = {1'b0, frameWakeFlag, pinWakeFlag, magicWakeFlag,
                        secondaryLinkState, secondaryLinkChangedFlag,
                        primaryLinkState, primaryLinkChangedFlag};

  always_comb begin
    readValue = '0;
    mapped = 1'b1;
    if (isReg(paddr, IDX_PHY_CONTROL)) begin
      readValue = {31'h0, phySelectEmbedded};
    end else if (isReg(paddr, IDX_WAKE_IRQ_ENABLE)) begin
      readValue = {24'h0, wakeIrqEnable};
    end else if (isReg(paddr, IDX_LINK_IRQ_ENABLE)) begin
      readValue = {24'h0, linkIrqEnable};
    end else if (isReg(paddr, IDX_WAKE_LINK_STATUS)) begin
      readValue = {24'h0, statusValue}; // see RULE5
    end else if (isReg(paddr, IDX_WAKE_FILTER_COMMAND)) begin
      readValue = {24'h0, wakeFilterCommand};
    end else if (isReg(paddr, IDX_STATION_LOW)) begin
      readValue = stationMacAddress[31:0];
    end else if (isReg(paddr, IDX_STATION_HIGH)) begin
      readValue = {16'h0, stationMacAddress[47:32]};
    end else begin
      mapped = 1'b0;
      for (int k = 0; k < 2; k++) begin
        if (isReg(paddr, IDX_FILTER_MASK[k])) begin
          readValue = filterMask[k];
          mapped = 1'b1;
        end else if (isReg(paddr, IDX_FILTER_CRC[k])) begin
          readValue = {16'h0, filterCrc[k]};
          mapped = 1'b1;
        end else if (isReg(paddr, IDX_FILTER_START[k])) begin
          readValue = {24'h0, filterStart[k]};
          mapped = 1'b1;
        end else if (isReg(paddr, IDX_FILTER_TAIL[k])) begin
          readValue = {24'h0, filterTail[k]};
          mapped = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      prdata <= '0;
      pslverr <= 1'b0;
    end else if (setupPhase) begin
      prdata <= pwrite ? '0 : readValue;
      pslverr <= ~mapped;
    end
  end

  // Control registers
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      phySelectEmbedded <= PHY_SEL_RESET;
      wakeIrqEnable <= BYTE_RESET;
      linkIrqEnable <= BYTE_RESET;
      wakeFilterCommand <= BYTE_RESET;
      stationMacAddress <= STATION_RESET;
    end else if (wrEn) begin
      if (isReg(paddr, IDX_PHY_CONTROL)) begin
        phySelectEmbedded <= pwdata[PCR_PHY_SEL]; // see RULE21
      end
      if (isReg(paddr, IDX_WAKE_IRQ_ENABLE)) begin
        wakeIrqEnable <= pwdata[7:0] & 8'h75;
      end
      if (isReg(paddr, IDX_LINK_IRQ_ENABLE)) begin
        linkIrqEnable <= pwdata[7:0] & 8'h05; // see RULE3
      end
      if (isReg(paddr, IDX_WAKE_FILTER_COMMAND)) begin
        wakeFilterCommand <= pwdata[7:0] & 8'h1f;
      end
      if (isReg(paddr, IDX_STATION_LOW)) begin
        stationMacAddress[31:0] <= pwdata;
      end
      if (isReg(paddr, IDX_STATION_HIGH)) begin
        stationMacAddress[47:32] <= pwdata[15:0];
      end
    end
  end

  for (genvar k = 0; k < 2; k++) begin : g_filter_regs
    always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
        filterMask[k] <= MASK_RESET;
        filterCrc[k] <= CRC_RESET;
        filterStart[k] <= BYTE_RESET;
        filterTail[k] <= BYTE_RESET;
      end else if (wrEn) begin
        if (isReg(paddr, IDX_FILTER_MASK[k])) begin
          filterMask[k] <= pwdata; // see RULE15
        end
        if (isReg(paddr, IDX_FILTER_CRC[k])) begin
          filterCrc[k] <= pwdata[15:0];
        end
        if (isReg(paddr, IDX_FILTER_START[k])) begin
          filterStart[k] <= pwdata[7:0];
        end
        if (isReg(paddr, IDX_FILTER_TAIL[k])) begin
          filterTail[k] <= pwdata[7:0];
        end
      end
    end
  end

  // Link polling
  assign pollTick = (pollCnt == POLL_W'(PollCycles - 1));
  assign primaryChange = pollTick & (primaryLinkUp != primaryLinkState); // see RULE2
  assign secondaryChange = pollTick & (secondaryLinkUp != secondaryLinkState); // see RULE2

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pollCnt <= '0;
    end else begin
      pollCnt <= pollTick ? '0 : pollCnt + 1'b1; // see RULE1
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      primaryLinkState <= 1'b0;
      secondaryLinkState <= 1'b0;
    end else if (pollTick) begin
      primaryLinkState <= primaryLinkUp; // see RULE5
      secondaryLinkState <= secondaryLinkUp;
    end
  end

  // Wake sources gated by their enables
  assign pinWakeSet = externalWakePin & ~pinLast & wakeIrqEnable[WIE_PIN];
  assign magicWakeSet = magicPacketSeen & wakeIrqEnable[WIE_MAGIC];

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pinLast <= 1'b0;
    end else begin
      pinLast <= externalWakePin;
    end
  end

  // Flags clear only for bits seen by the read, and a new event wins over the clear
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      primaryLinkChangedFlag <= 1'b0;
      secondaryLinkChangedFlag <= 1'b0;
      magicWakeFlag <= 1'b0;
      pinWakeFlag <= 1'b0;
      frameWakeFlag <= 1'b0;
    end else begin
      primaryLinkChangedFlag <= primaryChange |
        (primaryLinkChangedFlag & ~(statusRead & prdata[ST_PRI_FLAG])); // see RULE4
      secondaryLinkChangedFlag <= secondaryChange |
        (secondaryLinkChangedFlag & ~(statusRead & prdata[ST_SEC_FLAG])); // see RULE4
      magicWakeFlag <= magicWakeSet |
        (magicWakeFlag & ~(statusRead & prdata[ST_MAGIC])); // see RULE6
      pinWakeFlag <= pinWakeSet |
        (pinWakeFlag & ~(statusRead & prdata[ST_PIN])); // see RULE7
      frameWakeFlag <= frameWakeSet |
        (frameWakeFlag & ~(statusRead & prdata[ST_FRAME])); // see RULE8
    end
  end

  // Interrupt lines are levels held while an enabled flag is pending
  assign linkIrq = (primaryLinkChangedFlag & linkIrqEnable[LIE_PRI]) |
                   (secondaryLinkChangedFlag & linkIrqEnable[LIE_SEC]); // see RULE1
  assign wakeIrq = magicWakeFlag | pinWakeFlag | frameWakeFlag |
    (primaryLinkChangedFlag & primaryLinkState & wakeIrqEnable[WIE_PRI_UP]) |
    (secondaryLinkChangedFlag & secondaryLinkState & wakeIrqEnable[WIE_SEC_UP]); // see RULE22

  // Receive frame tracking; a frame start during evaluation is not seen
  assign firstByte = rxValid & rxSof & (rxState == RX_IDLE);
  assign accept = firstByte | (rxValid & (rxState == RX_RECV));
  assign byteIdx = (rxState == RX_IDLE) ? 11'h000 : posCnt;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rxState <= RX_IDLE;
      posCnt <= '0;
    end else begin
      unique case (rxState)
        RX_IDLE: begin
          if (firstByte) begin
            rxState <= rxEof ? RX_EVAL : RX_RECV;
            posCnt <= 11'h001;
          end
        end
        RX_RECV: begin
          if (rxValid) begin
            if (rxEof) begin
              rxState <= RX_EVAL;
            end
            if (posCnt != '1) begin
              posCnt <= posCnt + 1'b1;
            end
          end
        end
        RX_EVAL: begin
          rxState <= RX_IDLE;
        end
        default: begin
          rxState <= RX_IDLE;
        end
      endcase
    end
  end

  assign cascade = wakeFilterCommand[CMD_CASCADE];
  assign winStart[0] = {2'b00, filterStart[0], 1'b0}; // see RULE17
  assign winStart[1] = cascade ?
    winStart[0] + CASCADE_GAP + {2'b00, filterStart[1], 1'b0} : // see RULE14
    {2'b00, filterStart[1], 1'b0};
  assign feed[0] = cascade ? 1'b0 : hit[0];
  assign feed[1] = cascade ? (hit[0] | hit[1]) : hit[1]; // see RULE12

  for (genvar k = 0; k < 2; k++) begin : g_filter
    logic [10:0] rel;
    logic [15:0] crcBase;
    assign rel = byteIdx - winStart[k];
    assign hit[k] = accept & (byteIdx >= winStart[k]) & (rel < FILTER_SPAN) &
                    filterMask[k][rel[4:0]]; // see RULE19
    assign crcBase = firstByte ? CRC16_INIT : crcAcc[k];

    always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
        crcAcc[k] <= CRC16_INIT;
        tailAcc[k] <= BYTE_RESET;
        anyAcc[k] <= 1'b0;
      end else if (accept) begin
        crcAcc[k] <= feed[k] ? crc16Byte(crcBase, rxData) : crcBase; // see RULE24
        if (feed[k]) begin
          tailAcc[k] <= rxData; // see RULE18
        end
        anyAcc[k] <= feed[k] | (anyAcc[k] & ~firstByte);
      end
    end
  end

  assign daSel = 3'h5 - byteIdx[2:0];

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      daMatch <= 1'b0;
    end else if (accept && byteIdx < DA_BYTES) begin
      daMatch <= (firstByte | daMatch) &
                 (rxData == stationMacAddress[{daSel, 3'b000} +: 8]); // see RULE11
    end
  end

  assign filterHit[0] = wakeFilterCommand[CMD_F0_EN] & anyAcc[0] &
    (crcAcc[0] == filterCrc[0]) & (tailAcc[0] == filterTail[0]) &
    (~wakeFilterCommand[CMD_F0_UNI] | daMatch); // see RULE16
  assign filterHit[1] = wakeFilterCommand[CMD_F1_EN] & anyAcc[1] &
    (crcAcc[1] == filterCrc[1]) & (tailAcc[1] == filterTail[1]) &
    (~wakeFilterCommand[CMD_F1_UNI] | daMatch); // see RULE10
  assign frameMatch = cascade ? (wakeFilterCommand[CMD_F0_EN] & filterHit[1]) :
                      (filterHit[0] | filterHit[1]);
  assign frameWakeSet = (rxState == RX_EVAL) & frameMatch & wakeIrqEnable[WIE_FRAME];

  sequence s_frame_done;
    rxValid && rxEof && rxState == RX_RECV ##1 rxState == RX_EVAL;
  endsequence

  property p_link_irq;
    @(posedge clk) disable iff (!resetn)
      primaryChange && linkIrqEnable[LIE_PRI] |=> linkIrq;
  endproperty
  a_link_irq: assert property (p_link_irq) else $error("link change without irq"); // see RULE1

  property p_change_flag;
    @(posedge clk) disable iff (!resetn)
      pollTick && (secondaryLinkUp != secondaryLinkState) |=> secondaryLinkChangedFlag;
  endproperty
  a_change_flag: assert property (p_change_flag) else $error("change flag not set"); // see RULE4

  property p_state_follow;
    @(posedge clk) disable iff (!resetn)
      pollTick |=> primaryLinkState == $past(primaryLinkUp);
  endproperty
  a_state_follow: assert property (p_state_follow) else $error("state not sampled"); // see RULE5

  property p_read_clears;
    @(posedge clk) disable iff (!resetn)
      statusRead && prdata[ST_PIN] && !pinWakeSet |=> !pinWakeFlag;
  endproperty
  a_read_clears: assert property (p_read_clears) else $error("flag survives read"); // see RULE7

  property p_magic_set;
    @(posedge clk) disable iff (!resetn)
      magicPacketSeen && wakeIrqEnable[WIE_MAGIC] |=> magicWakeFlag && wakeIrq;
  endproperty
  a_magic_set: assert property (p_magic_set) else $error("magic wake lost"); // see RULE6

  property p_sec_gate;
    @(posedge clk) disable iff (!resetn)
      secondaryLinkChangedFlag && !linkIrqEnable[LIE_SEC] &&
      !(primaryLinkChangedFlag && linkIrqEnable[LIE_PRI]) |-> !linkIrq;
  endproperty
  a_sec_gate: assert property (p_sec_gate) else $error("link irq while disabled"); // see RULE3

  property p_frame_eval;
    @(posedge clk) disable iff (!resetn)
      s_frame_done ##0 (frameMatch && wakeIrqEnable[WIE_FRAME]) |=> frameWakeFlag;
  endproperty
  a_frame_eval: assert property (p_frame_eval) else $error("frame wake lost"); // see RULE8

  property p_phy_sel;
    @(posedge clk) disable iff (!resetn)
      wrEn && isReg(paddr, IDX_PHY_CONTROL) |=> phySelectEmbedded == $past(pwdata[0]);
  endproperty
  a_phy_sel: assert property (p_phy_sel) else $error("phy select not written"); // see RULE21

endmodule // ewf_wake_link

`default_nettype wire

// *** rtl/ewf_pkg.sv ***
// Constants and types shared by the wake and link status block
package ewf_pkg;

  localparam int unsigned ADDR_W = 12;
  localparam int unsigned DATA_W = 32;

  // Register indices; byte address is four times the index
  localparam logic [9:0] IDX_PHY_CONTROL = 10'h022;
  localparam logic [9:0] IDX_WAKE_IRQ_ENABLE = 10'h024;
  localparam logic [9:0] IDX_LINK_IRQ_ENABLE = 10'h026;
  localparam logic [9:0] IDX_WAKE_LINK_STATUS = 10'h028;
  localparam logic [9:0] IDX_WAKE_FILTER_COMMAND = 10'h030;
  localparam logic [9:0] IDX_FILTER_MASK [2] = '{10'h032, 10'h040};
  localparam logic [9:0] IDX_FILTER_CRC [2] = '{10'h036, 10'h044};
  localparam logic [9:0] IDX_FILTER_START [2] = '{10'h038, 10'h046};
  localparam logic [9:0] IDX_FILTER_TAIL [2] = '{10'h03a, 10'h048};
  localparam logic [9:0] IDX_STATION_LOW = 10'h050;
  localparam logic [9:0] IDX_STATION_HIGH = 10'h051;

  // wake_link_status fields
  localparam int unsigned ST_PRI_FLAG = 0;
  localparam int unsigned ST_PRI_STATE = 1;
  localparam int unsigned ST_SEC_FLAG = 2;
  localparam int unsigned ST_SEC_STATE = 3;
  localparam int unsigned ST_MAGIC = 4;
  localparam int unsigned ST_PIN = 5;
  localparam int unsigned ST_FRAME = 6;

  // wake_filter_command fields
  localparam int unsigned CMD_F0_EN = 0;
  localparam int unsigned CMD_F0_UNI = 1;
  localparam int unsigned CMD_F1_EN = 2;
  localparam int unsigned CMD_F1_UNI = 3;
  localparam int unsigned CMD_CASCADE = 4;

  // Link change and wake enable fields
  localparam int unsigned LIE_PRI = 0;
  localparam int unsigned LIE_SEC = 2;
  localparam int unsigned WIE_PRI_UP = 0;
  localparam int unsigned WIE_SEC_UP = 2;
  localparam int unsigned WIE_MAGIC = 4;
  localparam int unsigned WIE_PIN = 5;
  localparam int unsigned WIE_FRAME = 6;
  localparam int unsigned PCR_PHY_SEL = 0;

  // Reset values
  localparam logic PHY_SEL_RESET = 1'b1;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [15:0] CRC_RESET = 16'h0000;
  localparam logic [31:0] MASK_RESET = 32'h0000_0000;
  localparam logic [47:0] STATION_RESET = 48'h0000_0000_0000;

  // Filter arithmetic
  localparam logic [15:0] CRC16_POLY = 16'h8005;
  localparam logic [15:0] CRC16_INIT = 16'h0000;
  localparam logic [10:0] CASCADE_GAP = 11'h020;
  localparam logic [10:0] FILTER_SPAN = 11'h020;
  localparam logic [10:0] DA_BYTES = 11'h006;

  // Link poll period
  localparam int unsigned LINK_POLL_MS = 200;
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned LINK_POLL_CYCLES = LINK_POLL_MS * (CLK_HZ / 1000);
  localparam int unsigned POLL_W = 25;

  typedef enum logic [2:0] {
    RX_IDLE = 3'b001,
    RX_RECV = 3'b010,
    RX_EVAL = 3'b100
  } ewf_rx_state_t;

endpackage

// *** dv/ewf_rx_source.sv ***
// Receive frame source standing in for the MAC receive path
`timescale 1ns/1ps
`default_nettype none

module ewf_rx_source (
  input wire logic clk,
  output var logic rxValid,
  output var logic rxSof,
  output var logic rxEof,
  output var logic [7:0] rxData
);
  logic [7:0] frame [48];

  initial begin
    for (int i = 0; i < 48; i++) begin
      frame[i] = 8'(i * 29 + 7);
    end
    frame[0] = 8'h12;
    frame[1] = 8'h34;
    frame[2] = 8'h56;
    frame[3] = 8'h78;
    frame[4] = 8'h9a;
    frame[5] = 8'hbc;
    rxValid = 1'b0;
    rxSof = 1'b0;
    rxEof = 1'b0;
    rxData = 8'h00;
  end

  // Byte 0 is the first destination byte; data flips when idle so stale bytes never match
  task automatic send(input int len);
    for (int i = 0; i < len; i++) begin
      @(posedge clk);
      rxValid <= 1'b1;
      rxSof <= (i == 0);
      rxEof <= (i == len - 1);
      rxData <= frame[i];
    end
    @(posedge clk);
    rxValid <= 1'b0;
    rxSof <= 1'b0;
    rxEof <= 1'b0;
    rxData <= ~frame[len - 1];
  endtask
endmodule // ewf_rx_source

`default_nettype wire

// *** dv/ewf_wake_link_bench.sv ***
// Self-checking bench for the wake and link status block
`timescale 1ns/1ps
`default_nettype none

module ewf_wake_link_bench;
  import ewf_pkg::*;
  localparam int unsigned Poll = 16;
  logic clk, resetn, psel, penable, pwrite, priUp, secUp, magic, pin;
  logic [ADDR_W-1:0] paddr;
  logic [DATA_W-1:0] pwdata, prdata, rd;
  logic pready, pslverr, linkIrq, wakeIrq, phySel, rxValid, rxSof, rxEof, err;
  logic [7:0] rxData;
  int errTotal, nTests;
  localparam logic [9:0] RIDX [10] = '{IDX_PHY_CONTROL, IDX_WAKE_LINK_STATUS,
    IDX_WAKE_FILTER_COMMAND, IDX_FILTER_MASK[0], IDX_FILTER_CRC[0], IDX_FILTER_START[0],
    IDX_FILTER_TAIL[0], IDX_FILTER_MASK[1], IDX_WAKE_IRQ_ENABLE, IDX_LINK_IRQ_ENABLE};

  ewf_wake_link #(.PollCycles(Poll)) i_ewf_wake_link (.clk(clk), .resetn(resetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .primaryLinkUp(priUp), .secondaryLinkUp(secUp),
    .magicPacketSeen(magic), .externalWakePin(pin), .rxValid(rxValid), .rxSof(rxSof),
    .rxEof(rxEof), .rxData(rxData), .linkIrq(linkIrq), .wakeIrq(wakeIrq),
    .phySelectEmbedded(phySel));
  ewf_rx_source i_ewf_rx_source (.clk(clk), .rxValid(rxValid), .rxSof(rxSof), .rxEof(rxEof),
    .rxData(rxData));

  always #5 clk = ~clk;

  task automatic summarize();
    $display("checks %0d mismatches %0d", nTests, errTotal);
    if (errTotal == 0 && nTests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    nTests++;
    if (got !== exp) begin
      errTotal++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask

  // One APB transfer; request held until pready is seen high at a rising edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int g;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    g = 0;
    do begin
      @(posedge clk);
      g++;
    end while (pready !== 1'b1 && g < 16);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) chk("pready", 32'h1, {31'h0, pready});
  endtask

  task automatic wr(input logic [9:0] i, input logic [31:0] d);
    apb(1'b1, {i, 2'b00}, d);
  endtask

  task automatic rdx(input logic [9:0] i, input logic [31:0] exp, input string name);
    apb(1'b0, {i, 2'b00}, 32'h0);
    chk(name, exp, rd);
  endtask

  function automatic logic [15:0] crcStep(input logic [15:0] c, input logic [7:0] d);
    logic fb;
    for (int b = 0; b < 8; b++) begin
      fb = c[15] ^ d[b];
      c = {c[14:0], 1'b0};
      if (fb) c = c ^ CRC16_POLY;
    end
    return c;
  endfunction

  // Filters programmed first, command last; filter 0 crc/tail scrambled when cascaded
  task automatic filt(input logic [7:0] cmd, input logic [31:0] m0, input int s0,
    input logic [31:0] m1, input int s1, input logic bad, input logic exp);
    logic [15:0] c;
    logic [7:0] t;
    int base;
    c = 16'h0000;
    t = 8'h00;
    base = cmd[CMD_CASCADE] ? 2 * s0 + 32 + 2 * s1 : 2 * s1;
    for (int n = 0; n < 32; n++) begin
      if (cmd[CMD_F0_EN] && m0[n]) begin
        c = crcStep(c, i_ewf_rx_source.frame[2 * s0 + n]);
        t = i_ewf_rx_source.frame[2 * s0 + n];
      end
    end
    for (int n = 0; n < 32; n++) begin
      if (cmd[CMD_F1_EN] && m1[n]) begin
        c = crcStep(c, i_ewf_rx_source.frame[base + n]);
        t = i_ewf_rx_source.frame[base + n];
      end
    end
    c = c ^ {bad, 15'h0};
    wr(IDX_FILTER_MASK[0], m0);
    wr(IDX_FILTER_START[0], 32'(s0));
    wr(IDX_FILTER_MASK[1], m1);
    wr(IDX_FILTER_START[1], 32'(s1));
    wr(IDX_FILTER_CRC[0], {16'h0, c ^ (cmd[CMD_CASCADE] ? 16'h5a5a : 16'h0)});
    wr(IDX_FILTER_TAIL[0], {24'h0, t ^ (cmd[CMD_CASCADE] ? 8'h5a : 8'h0)});
    wr(IDX_FILTER_CRC[1], {16'h0, c});
    wr(IDX_FILTER_TAIL[1], {24'h0, t});
    wr(IDX_WAKE_FILTER_COMMAND, {24'h0, cmd});
    i_ewf_rx_source.send(48);
    repeat (4) @(posedge clk);
    chk("wakeIrq frame", {31'h0, exp}, {31'h0, wakeIrq});
    rdx(IDX_WAKE_LINK_STATUS, {25'h0, exp, 6'h08}, "status frame");
    wr(IDX_WAKE_FILTER_COMMAND, 32'h0);
  endtask

  initial begin
    #100us;
    errTotal++;
    $display("ERROR watchdog expected done seen hang");
    summarize();
  end

  initial begin
    {clk, resetn, psel, penable, pwrite, priUp, secUp, magic, pin} = '0;
    paddr = '0;
    pwdata = '0;
    repeat (8) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    chk("phySel reset", 32'h1, {31'h0, phySel});
    for (int i = 0; i < 10; i++) rdx(RIDX[i], {31'h0, i == 0}, "reset value");
    wr(IDX_PHY_CONTROL, 32'h0);
    @(posedge clk);
    chk("phySel mii", 32'h0, {31'h0, phySel});
    wr(IDX_PHY_CONTROL, 32'h1);
    wr(IDX_WAKE_FILTER_COMMAND, 32'hffffffff);
    rdx(IDX_WAKE_FILTER_COMMAND, 32'h1f, "command bits");
    wr(IDX_WAKE_FILTER_COMMAND, 32'h0);
    wr(IDX_WAKE_LINK_STATUS, 32'hff);
    rdx(IDX_WAKE_LINK_STATUS, 32'h0, "status read only");
    apb(1'b0, 12'h7fc, 32'h0);
    chk("unmapped err", 32'h1, {31'h0, err});
    chk("unmapped data", 32'h0, rd);
    // Link polling with a shortened period
    wr(IDX_LINK_IRQ_ENABLE, 32'h5);
    priUp <= 1'b1;
    repeat (2 * Poll + 4) @(posedge clk);
    chk("linkIrq up", 32'h1, {31'h0, linkIrq});
    rdx(IDX_WAKE_LINK_STATUS, 32'h03, "status pri up");
    rdx(IDX_WAKE_LINK_STATUS, 32'h02, "status cleared");
    @(posedge clk);
    chk("linkIrq cleared", 32'h0, {31'h0, linkIrq});
    wr(IDX_LINK_IRQ_ENABLE, 32'h1);
    secUp <= 1'b1;
    repeat (2 * Poll + 4) @(posedge clk);
    chk("linkIrq sec off", 32'h0, {31'h0, linkIrq});
    rdx(IDX_WAKE_LINK_STATUS, 32'h0e, "status sec up");
    priUp <= 1'b0;
    repeat (2 * Poll + 4) @(posedge clk);
    chk("linkIrq down", 32'h1, {31'h0, linkIrq});
    rdx(IDX_WAKE_LINK_STATUS, 32'h09, "status pri down");
    // Wake sources
    wr(IDX_WAKE_IRQ_ENABLE, 32'h70);
    magic <= 1'b1;
    @(posedge clk);
    magic <= 1'b0;
    repeat (3) @(posedge clk);
    chk("wakeIrq magic", 32'h1, {31'h0, wakeIrq});
    rdx(IDX_WAKE_LINK_STATUS, 32'h18, "status magic");
    @(posedge clk);
    chk("wakeIrq cleared", 32'h0, {31'h0, wakeIrq});
    pin <= 1'b1;
    repeat (3) @(posedge clk);
    chk("wakeIrq pin", 32'h1, {31'h0, wakeIrq});
    rdx(IDX_WAKE_LINK_STATUS, 32'h28, "status pin");
    pin <= 1'b0;
    wr(IDX_WAKE_IRQ_ENABLE, 32'h40);
    magic <= 1'b1;
    @(posedge clk);
    magic <= 1'b0;
    repeat (3) @(posedge clk);
    rdx(IDX_WAKE_LINK_STATUS, 32'h08, "status magic off");
    // Wake frame filters
    filt(8'h01, 32'h0000303f, 0, 32'h0, 0, 1'b0, 1'b1);
    filt(8'h01, 32'h0000303f, 0, 32'h0, 0, 1'b1, 1'b0);
    filt(8'h04, 32'h0, 0, 32'h00000005, 1, 1'b0, 1'b1);
    filt(8'h03, 32'h0000303f, 0, 32'h0, 0, 1'b0, 1'b0);
    filt(8'h15, 32'h00000003, 1, 32'h00000003, 2, 1'b0, 1'b1);
    filt(8'h00, 32'h0000303f, 0, 32'h0, 0, 1'b0, 1'b0);
    filt(8'h0c, 32'h0, 0, 32'h00000005, 1, 1'b0, 1'b0);
    wr(IDX_STATION_HIGH, 32'h00001234);
    wr(IDX_STATION_LOW, 32'h56789abc);
    filt(8'h03, 32'h0000303f, 0, 32'h0, 0, 1'b0, 1'b1);
    filt(8'h0c, 32'h0, 0, 32'h00000005, 1, 1'b0, 1'b1);
    rdx(IDX_WAKE_LINK_STATUS, 32'h08, "status frame cleared");
    // Link-up wake path through the wake enable
    wr(IDX_WAKE_IRQ_ENABLE, 32'h01);
    priUp <= 1'b1;
    repeat (2 * Poll + 4) @(posedge clk);
    chk("wakeIrq link up", 32'h1, {31'h0, wakeIrq});
    rdx(IDX_WAKE_LINK_STATUS, 32'h0b, "status link up wake");
    @(posedge clk);
    chk("wakeIrq link cleared", 32'h0, {31'h0, wakeIrq});
    summarize();
  end
endmodule // ewf_wake_link_bench

`default_nettype wire
